// *** epe_emulator.sv ***
/*
  Emulated incremental encoder output with APB registers.
  Assumes shaft steps and overflow events come from logic on clk_in,
  and MOTOR_CPR shaft steps make one revolution.
*/
module epe_emulator (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [7:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic [31:0]              prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  input  wire logic                shaft_step_in,
  input  wire logic                shaft_dir_in,
  input  wire logic                overflow_in,
  output logic                     enc_a_out,
  output logic                     enc_b_out,
  output logic                     enc_z_out,
  output logic                     alarm_out,
  output logic                     irq_out
);
  import epe_pkg::*;

  // ==========================================================
  // declarations
  logic [14:0] lines_reg;
  logic [14:0] lines_next;
  epe_cfg_t    cfg_reg;
  epe_cfg_t    cfg_next;
  logic [1:0]  status_reg;
  logic [1:0]  status_next;
  logic [1:0]  mask_reg;
  logic [1:0]  mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic [16:0] acc_reg;
  logic [16:0] acc_next;
  logic [16:0] qpos_reg;
  logic [16:0] qpos_next;
  logic        setup;
  logic        wr;
  logic        mapped;
  logic        wr_lines;
  logic        wr_cfg;
  logic        wr_status;
  logic        wr_mask;
  logic [1:0]  status_set;
  logic [1:0]  status_clr;
  logic [16:0] cpr_q;
  logic [17:0] acc_sum;
  logic        emit;
  logic        step_ok;
  logic        alarm;
  epe_pins_t   pins;

  // ==========================================================
  // bus decode
  always_comb begin
    setup  = psel_in && !penable_in;
    wr     = psel_in && penable_in && pwrite_in;
    mapped = (paddr_in == OFS_LINES) || (paddr_in == OFS_CFG)
             || (paddr_in == OFS_STATUS) || (paddr_in == OFS_IRQ_MASK)
             || (paddr_in == OFS_POSITION);
    wr_lines  = wr && (paddr_in == OFS_LINES);
    wr_cfg    = wr && (paddr_in == OFS_CFG);
    wr_status = wr && (paddr_in == OFS_STATUS);
    wr_mask   = wr && (paddr_in == OFS_IRQ_MASK);
  end

  // ==========================================================
  // configuration registers
  always_comb begin
    lines_next = lines_reg;
    cfg_next   = cfg_reg;
    mask_next  = mask_reg;
    if (wr_lines) begin
      // out of range writes are clamped to the nearest limit
      if (pwdata_in == 32'h0000_0000) begin
        lines_next = LINES_MIN; // R01
      end else if (pwdata_in > {17'h0, LINES_MAX}) begin
        lines_next = LINES_MAX; // R01
      end else begin
        lines_next = pwdata_in[14:0]; // R01
      end
    end
    if (wr_cfg) begin
      cfg_next = pwdata_in[3:0];
    end
    if (wr_mask) begin
      mask_next = pwdata_in[1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lines_reg <= LINES_RST; // R01
      cfg_reg   <= CFG_RST; // R05 R08
      mask_reg  <= MASK_RST;
    end else begin
      lines_reg <= lines_next;
      cfg_reg   <= cfg_next;
      mask_reg  <= mask_next;
    end
  end

  // ==========================================================
  // status and interrupt
  always_comb begin
    status_set         = 2'h0;
    status_set[ST_OVF] = overflow_in;
    status_set[ST_IDX] = emit && (qpos_next == 17'h0);
    status_clr = wr_status ? pwdata_in[1:0] : 2'h0;
    // a new event in the clearing cycle survives
    status_next = (status_reg & ~status_clr) | status_set;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg <= ST_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  always_comb begin
    alarm = status_reg[ST_OVF] && !cfg_reg.multiturn_overflow_mask; // R08
  end

  // ==========================================================
  // read data, captured in the setup cycle
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      err_next   = !mapped;
      rdata_next = 32'h0000_0000;
      unique case (paddr_in)
        OFS_LINES:    rdata_next[14:0] = lines_reg;
        OFS_CFG:      rdata_next[3:0]  = cfg_reg;
        OFS_STATUS:   rdata_next[1:0]  = status_reg;
        OFS_IRQ_MASK: rdata_next[1:0]  = mask_reg;
        OFS_POSITION: begin
          rdata_next[16:0]      = qpos_reg;
          rdata_next[POS_ALARM] = alarm;
        end
        default:      rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  // ==========================================================
  // shaft steps to quadrature counts
  always_comb begin
    cpr_q    = epe_counts_per_rev(lines_reg); // R02
    // an active alarm stops the pulse train
    step_ok  = shaft_step_in && !alarm; // R08
    acc_sum  = {1'b0, acc_reg} + {1'b0, cpr_q};
    acc_next = acc_reg;
    qpos_next = qpos_reg;
    emit     = 1'b0;
    if (wr_lines) begin
      // new resolution restarts the revolution at the index
      acc_next  = 17'h0;
      qpos_next = 17'h0;
    end else if (step_ok && shaft_dir_in) begin
      // cpr_q counts per MOTOR_CPR steps, so exactly 4 x lines a turn
      if (acc_sum >= MOTOR_CPR) begin
        acc_next = 17'(acc_sum - MOTOR_CPR); // R02
        emit     = 1'b1;
        qpos_next = (qpos_reg == 17'(cpr_q - 17'h1))
                    ? 17'h0 : 17'(qpos_reg + 17'h1); // R09
      end else begin
        acc_next = acc_sum[16:0];
      end
    end else if (step_ok) begin
      if (acc_reg < cpr_q) begin
        acc_next = 17'(acc_reg + MOTOR_CPR - cpr_q); // R02
        emit     = 1'b1;
        qpos_next = (qpos_reg == 17'h0)
                    ? 17'(cpr_q - 17'h1) : 17'(qpos_reg - 17'h1); // R09
      end else begin
        acc_next = 17'(acc_reg - cpr_q);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_reg  <= 17'h0;
      qpos_reg <= 17'h0;
    end else begin
      acc_reg  <= acc_next;
      qpos_reg <= qpos_next;
    end
  end

  // ==========================================================
  // pin stage
  epe_quad_out u_quad (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .qpos_in  (qpos_reg),
    .lines_in (lines_reg),
    .cfg_in   (cfg_reg),
    .pins_out (pins)
  );

  // ==========================================================
  // outputs
  always_comb begin
    enc_a_out   = pins.a;
    enc_b_out   = pins.b;
    // host should time from the leading index edge
    enc_z_out   = pins.z; // R07
    alarm_out   = alarm; // R08
    irq_out     = |(status_reg & mask_reg);
    pready_out  = 1'b1;
    prdata_out  = rdata_reg;
    pslverr_out = psel_in && penable_in && err_reg;
  end

endmodule // epe_emulator

// *** epe_emulator_chk.sv ***
/* Port checker of the encoder emulator.
   Bound into epe_emulator; sees only its ports. */
module epe_emulator_chk (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        shaft_step_in,
  input wire logic        overflow_in,
  input wire logic        enc_a_out,
  input wire logic        enc_b_out,
  input wire logic        enc_z_out,
  input wire logic        alarm_out
);
  logic       wr;
  logic [2:0] h_reg;
  logic       ovf_reg;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========
  // history: writes and reset may move pins legally
  assign wr = psel_in && penable_in && pwrite_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      h_reg <= 3'h7;
      ovf_reg <= 1'b0;
    end else begin
      h_reg <= {h_reg[1:0], wr};
      ovf_reg <= ovf_reg | overflow_in;
    end
  end
  // ==========
  // properties
  property p_quiet;
    h_reg == 3'h0 && !($past(shaft_step_in, 2) && !$past(alarm_out, 2))
      |-> $stable({enc_a_out, enc_b_out, enc_z_out});
  endproperty
  a_quiet: assert property (p_quiet) else $error("pins moved");
  property p_one_chan;
    h_reg == 3'h0 |-> !($changed(enc_a_out) && $changed(enc_b_out));
  endproperty
  a_one_chan: assert property (p_one_chan) else $error("a b both");
  property p_rdy;
    psel_in |-> pready_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("not ready");
  property p_err;
    psel_in && penable_in && paddr_in > 8'h10 |-> pslverr_out;
  endproperty
  a_err: assert property (p_err) else $error("no slverr");
  property p_rd0;
    psel_in && penable_in && !pwrite_in && paddr_in > 8'h10
      |-> prdata_out == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped data");
  property p_ok;
    psel_in && penable_in && paddr_in[1:0] == 2'h0 && paddr_in <= 8'h10
      |-> !pslverr_out;
  endproperty
  a_ok: assert property (p_ok) else $error("bad slverr");
  property p_alarm_cause;
    $rose(alarm_out) |-> $past(overflow_in) || $past(wr);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm");
  property p_alarm_ovf;
    alarm_out |-> ovf_reg;
  endproperty
  a_alarm_ovf: assert property (p_alarm_ovf) else $error("no ovf");
endmodule // epe_emulator_chk

bind epe_emulator epe_emulator_chk u_chk (.clk_in, .rst_n_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out,
  .pslverr_out, .shaft_step_in, .overflow_in, .enc_a_out, .enc_b_out,
  .enc_z_out, .alarm_out);

// *** epe_host_cap.sv ***
/* Host capture model: decodes A/B into a signed count and counts index
   leading edges. Assumes the pins are registered levels on clk_in. */
module epe_host_cap (
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  input  wire logic   a_in,
  input  wire logic   b_in,
  input  wire logic   z_in,
  input  wire logic   b_inv_in,
  input  wire logic   z_inv_in,
  output logic [31:0] cnt_out,
  output logic [31:0] idx_out
);
  logic [1:0] ph;
  logic [1:0] ph_q;
  logic       zq;
  // ==========
  // decode
  assign ph = {b_in ^ b_inv_in, a_in ^ b_in ^ b_inv_in};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_q <= 2'h0;
      zq <= 1'b0;
      cnt_out <= 32'h0;
      idx_out <= 32'h0;
    end else begin
      ph_q <= ph;
      zq <= z_in ^ z_inv_in;
      if (ph - ph_q == 2'h1) cnt_out <= cnt_out + 32'h1;
      if (ph - ph_q == 2'h3) cnt_out <= cnt_out - 32'h1;
      // leading edge only, so a widened pulse counts once
      if ((z_in ^ z_inv_in) && !zq) idx_out <= idx_out + 32'h1;
    end
  end
endmodule // epe_host_cap

// *** epe_pkg.sv ***
/*
  Constants, register map and carrier types of the emulated encoder
  pulse output. Assumes a single 40 MHz clock and an APB register port.
*/
// What this block does
// R01 - line count 1 to 16384, default 2500
// R02 - four quadrature counts per line per revolution
// R03 - b select 0: A lags CCW, leads CW
// R04 - b select 1: A leads CCW, lags CW
// R05 - index polarity normal at 0, inverted at 1
// R06 - index width one or four A widths
// R07 - host uses leading index edge as reference
// R08 - overflow alarms unless masked, mask defaults set
// R09 - one channel per count, one index per revolution
package epe_pkg;

  // ==========================================================
  // sizes
  localparam int          LINES_W      = 15;
  localparam int          QPOS_W       = 17;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;

  // ==========================================================
  // shaft resolution and line count limits
  // shaft steps per turn: plain default, one bit wider than the count
  localparam logic [17:0] MOTOR_CPR    = 18'h20000;
  localparam logic [14:0] LINES_MIN    = 15'h0001;
  localparam logic [14:0] LINES_MAX    = 15'h4000;
  localparam logic [14:0] LINES_RST    = 15'h09C4;
  localparam logic [16:0] Z_NARROW     = 17'h00002;
  localparam logic [16:0] Z_WIDE       = 17'h00008;

  // ==========================================================
  // register offsets
  localparam logic [7:0]  OFS_LINES    = 8'h00;
  localparam logic [7:0]  OFS_CFG      = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0]  OFS_POSITION = 8'h10;

  // ==========================================================
  // field positions
  localparam int          CFG_BPH      = 0;
  localparam int          CFG_ZPH      = 1;
  localparam int          CFG_ZW       = 2;
  localparam int          CFG_OVM      = 3;
  localparam int          ST_OVF       = 0;
  localparam int          ST_IDX       = 1;
  localparam int          POS_ALARM    = 31;
  localparam logic [3:0]  CFG_RST      = 4'h8;
  localparam logic [1:0]  ST_RST       = 2'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic multiturn_overflow_mask;
    logic index_width_select;
    logic index_phase_select;
    logic b_phase_select;
  } epe_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } epe_pins_t;

  // quadrature counts in one revolution
  function automatic logic [16:0] epe_counts_per_rev(
    input logic [14:0] lines
  );
    return {lines, 2'b00}; // R02
  endfunction

endpackage

// *** epe_quad_out.sv ***
/*
  Output stage: turns the quadrature position into A, B and Z levels.
  Assumes the position is kept below one revolution by the caller.
*/
module epe_quad_out (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [16:0]         qpos_in,
  input  wire logic [14:0]         lines_in,
  input  wire epe_pkg::epe_cfg_t   cfg_in,
  output epe_pkg::epe_pins_t       pins_out
);
  import epe_pkg::*;

  epe_pins_t   pins_reg;
  epe_pins_t   pins_next;
  logic [16:0] zwidth;
  logic [1:0]  phase;

  // ==========================================================
  // next levels
  always_comb begin
    phase  = qpos_in[1:0];
    // rising count is CW: A goes high one count before B when b_phase_select is 0
    pins_next.a = (phase == 2'h1) || (phase == 2'h2); // R09
    pins_next.b = ((phase == 2'h2) || (phase == 2'h3))
                  ^ cfg_in.b_phase_select; // R03 R04
    zwidth = cfg_in.index_width_select ? Z_WIDE : Z_NARROW; // R06
    // lines of 1 with wide index: pulse covers the whole turn
    pins_next.z = ((qpos_in < zwidth)
                   || (zwidth >= epe_counts_per_rev(lines_in)))
                  ^ cfg_in.index_phase_select; // R05 R09
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign pins_out = pins_reg;

endmodule // epe_quad_out

// *** tb.sv ***
/* Self-checking bench of epe_emulator with a host capture model.
   Assumes one 40 MHz clock and zero-wait APB. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0;
  logic        stp = 0, dir = 0, ovf = 0, binv = 0, zinv = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, c0, i0, cnt, icnt;
  logic [31:0] seed = 32'hCAC0;
  logic [31:0] rv [5] = '{32'h9C4, 32'h8, 32'h0, 32'h0, 32'h0};
  logic        pready, perr, a, b, z, alarm, irq, e;
  int          err_count = 0, check_count = 0, cyc = 0, n, l;
`define CK(g, x, m) begin check_count++; if ((g) !== (x)) begin \
  err_count++; $display("[ERR] %0t %s", $time, m); end end
  epe_emulator u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .shaft_step_in(stp), .shaft_dir_in(dir), .overflow_in(ovf),
    .enc_a_out(a), .enc_b_out(b), .enc_z_out(z), .alarm_out(alarm),
    .irq_out(irq));
  epe_host_cap u_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .a_in(a),
    .b_in(b), .z_in(z), .b_inv_in(binv), .z_inv_in(zinv), .cnt_out(cnt),
    .idx_out(icnt));
  // ==========
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_cnt(input int n, input int l);
    return 32'((n * 4 * l) / int'(epe_pkg::MOTOR_CPR));
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // trailing edges let pins and the host model settle
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1;
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic steps(input int n, input logic d);
    for (int i = 0; i < n; i++) begin
      stp <= 1;
      dir <= d;
      @(posedge clk_in);
      if (xs() % 2) begin
        stp <= 0;
        @(posedge clk_in);
      end
    end
    stp <= 0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic pulse();
    ovf <= 1;
    @(posedge clk_in);
    ovf <= 0;
    repeat (2) @(posedge clk_in);
  endtask
  initial forever #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // ==========
  // sequence
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1;
    repeat (2) @(posedge clk_in);
    `CK(z, 1'b1, "z at rest")
    for (int i = 0; i < 5; i++) begin
      apb(0, 8'(4 * i), 0);
      `CK(q, rv[i], "reset value")
    end
    apb(0, 8'h20, 0);
    `CK({e, q}, 33'h100000000, "unmapped")
    apb(1, 8'h00, 0);
    apb(0, 8'h00, 0);
    `CK(q, 32'h1, "lines floor")
    apb(1, 8'h00, 32'h4E20);
    apb(0, 8'h00, 0);
    `CK(q, 32'h4000, "lines ceiling")
    for (int k = 0; k < 4; k++) begin
      zinv <= k[0];
      apb(1, 8'h04, 32'(8 + 2 * k));
      apb(1, 8'h00, 32'h4000);
      `CK(z, ~k[0], "z active")
      steps(k[1] ? 14 : 2, 1);
      `CK(z, ~k[0], "z width")
      steps(2, 1);
      `CK(z, k[0], "z ended")
    end
    for (int k = 0; k < 2; k++) begin
      binv <= k[0];
      zinv <= 0;
      apb(1, 8'h04, 32'(8 + k));
      apb(1, 8'h00, 32'h4000);
      n = 4 + 2 * (xs() % 30);
      c0 = cnt;
      i0 = icnt;
      steps(n, 1);
      `CK(cnt - c0, 32'(n / 2), "cw phase")
      steps(n, 0);
      `CK(cnt - c0, 32'h0, "ccw phase")
      `CK(icnt - i0, 32'h1, "one index")
      apb(0, 8'h08, 0);
      `CK(q[1], 1'b1, "index status")
      apb(1, 8'h08, 32'h3);
    end
    repeat (3) begin
      l = 1 + xs() % 16384;
      apb(1, 8'h00, 32'(l));
      n = 1 + xs() % 255;
      c0 = cnt;
      steps(n, 1);
      `CK(cnt - c0, exp_cnt(n, l), "counts per line")
    end
    apb(1, 8'h0C, 32'h1);
    pulse();
    `CK({alarm, irq}, 2'b01, "masked overflow")
    apb(1, 8'h0C, 32'h0);
    `CK(irq, 1'b0, "irq masked")
    apb(0, 8'h08, 0);
    `CK(q[0], 1'b1, "overflow status")
    apb(1, 8'h08, 32'h1);
    binv <= 0;
    apb(1, 8'h04, 32'h0);
    apb(1, 8'h00, 32'h4000);
    pulse();
    `CK(alarm, 1'b1, "alarm on")
    apb(0, 8'h10, 0);
    `CK(q, 32'h8000_0000, "alarm in position")
    c0 = cnt;
    steps(4, 1);
    `CK(cnt - c0, 32'h0, "held by alarm")
    apb(1, 8'h08, 32'h1);
    `CK(alarm, 1'b0, "alarm cleared")
    steps(4, 1);
    `CK(cnt - c0, 32'h2, "resumed")
    apb(0, 8'h10, 0);
    `CK(q, 32'h0000_0002, "position after resume")
    tally_and_finish();
  end
endmodule // tb
